// file: pkg/seea_pkg.sv
package seea_pkg;
  // ---------------------------------------------------------------------
  // Register map inside the 0x6000-0x6FFF window.
  // ---------------------------------------------------------------------
  localparam logic [15:0] WIN_BASE     = 16'h6000;
  localparam logic [15:0] WIN_LAST     = 16'h6FFF;
  localparam logic [15:0] ADDR_OFS     = 16'h6000;
  localparam logic [15:0] DATA_OFS     = 16'h6004;
  localparam logic [15:0] CMD_OFS      = 16'h6008;
  localparam logic [15:0] CFG_OFS      = 16'h600C;
  localparam logic [15:0] STS_OFS      = 16'h6010;
  localparam logic [15:0] IRQ_STS_OFS  = 16'h6014;
  localparam logic [15:0] IRQ_MASK_OFS = 16'h6018;
  localparam int CMD_READ_BIT   = 0;
  localparam int CMD_WRITE_BIT  = 1;
  localparam int STS_RD_DONE    = 0;
  localparam int STS_RD_ERR     = 1;
  localparam int STS_WR_DONE    = 2;
  localparam int STS_WR_ERR     = 3;
  localparam int STS_BUSY       = 4;
  localparam int STS_BOOT_DONE  = 5;
  localparam int STS_DEFAULTS   = 6;
  localparam logic [1:0] SIZE_AUTO = 2'h0;
  localparam logic [1:0] SIZE_UNKNOWN = 2'h0;
  localparam logic [15:0] SIZE_ENTRIES [4] = '{16'h0000, 16'h0100, 16'h0200, 16'h0400};
  localparam logic [14:0] PROT_REGION_END [8] = '{15'h0020, 15'h0040, 15'h0080,
    15'h00C0, 15'h0100, 15'h0400, 15'h0800, 15'h1000};
  // ---------------------------------------------------------------------
  // Boot image layout.
  // ---------------------------------------------------------------------
  localparam logic [14:0] SIG_WORD_ADDR  = 15'h003D;
  localparam logic [15:0] SIG_VALUE      = 16'h5AA5;
  localparam logic [14:0] PROT_WORD_ADDR = 15'h003F;
  localparam int CONFIG_ENTRIES = 64;
  localparam int CIS_ENTRIES    = 128;
  localparam logic [14:0] BOOT_LAST = 15'(CONFIG_ENTRIES + CIS_ENTRIES - 1);
  // ---------------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int SCL_PERIOD_NS    = 10000;
  localparam int QTR_CYCLES       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int WRITE_MAX_MS     = 15;
  localparam int WRITE_MAX_CYCLES = WRITE_MAX_MS * (1000000 / CLK_PERIOD_NS);
  localparam int STRAP_SETTLE     = 4;
  typedef enum logic [1:0] {SEEA_OP_START, SEEA_OP_STOP, SEEA_OP_WR, SEEA_OP_RD} seea_op_e;
endpackage : seea_pkg

// file: verilog/seea_top.sv
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module seea_top #(
  parameter int         WRITE_POLL_CYCLES = seea_pkg::WRITE_MAX_CYCLES,
  parameter logic [6:0] DEV_ADDR          = 7'h50
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        boot_load_enable_pin_n,
  input  wire logic [1:0]  detected_size_field,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             cfg_load_valid,
  output logic      [7:0]  cfg_load_addr,
  output logic      [15:0] cfg_load_data,
  output logic             cfg_use_defaults,
  output logic             boot_done,
  output logic             irq
);
  // ---------------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------------
  localparam int DW = $clog2(seea_pkg::QTR_CYCLES);
  localparam logic [DW-1:0] DIV_LAST = DW'(seea_pkg::QTR_CYCLES - 1);
  localparam logic [31:0] POLL_LIMIT = 32'(WRITE_POLL_CYCLES);

  function automatic logic seea_prot_ok(input logic [15:0] prot, input logic [14:0] a,
                                        input logic wr);
    logic [3:0] r;
    logic [1:0] c;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (a < seea_pkg::PROT_REGION_END[i]) r = 4'(i);
    end
    c = r[3] ? 2'h0 : prot[{r[2:0], 1'b0} +: 2];
    return wr ? !c[1] : !c[0];
  endfunction : seea_prot_ok

  typedef enum logic [4:0] {S_STRAP, S_IDLE, S_START, S_DEVW, S_AHI, S_ALO, S_RSTART,
    S_DEVR, S_RDHI, S_RDLO, S_WRHI, S_WRLO, S_STOP, S_PSTART, S_PDEV, S_PSTOP,
    S_FINISH} seea_state_e;
  typedef enum logic [1:0] {B_SIG, B_PROT, B_LOAD} seea_boot_e;

  // ---------------------------------------------------------------------
  // Bit engine: one START, STOP or 9-bit byte slot per request.
  // ---------------------------------------------------------------------
  logic [DW-1:0] div_q, div_d;
  logic eb_q, eb_d, done_q, done_d, nack_q, nack_d, ackdrv_q, ackdrv_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  seea_pkg::seea_op_e kind_q, kind_d, op_kind;
  logic scl_low_q, scl_low_d, sda_low_q, sda_low_d;
  logic sda_s1_q, sda_s2_q, sda_s3_q, sda_f_q, sda_f_d;
  logic tick, drv, op_go, op_ack;
  logic [7:0] op_byte;

  assign tick = (div_q == DIV_LAST);
  assign drv  = (bit_q == 4'h8) ? (kind_q == seea_pkg::SEEA_OP_RD && ackdrv_q)
                                : (kind_q == seea_pkg::SEEA_OP_WR && !sh_q[7]);

  always_comb begin
    div_d = tick ? '0 : div_q + 1'b1;
    eb_d = eb_q; ph_d = ph_q; bit_d = bit_q; sh_d = sh_q; kind_d = kind_q;
    ackdrv_d = ackdrv_q; nack_d = nack_q; done_d = 1'b0;
    scl_low_d = scl_low_q; sda_low_d = sda_low_q;
    // The filtered level moves only once two late stages agree.
    sda_f_d = (sda_s2_q == sda_s3_q) ? sda_s3_q : sda_f_q;
    if (!eb_q) begin
      if (op_go) begin
        eb_d = 1'b1; ph_d = 2'h0; bit_d = 4'h0;
        sh_d = op_byte; kind_d = op_kind; ackdrv_d = op_ack;
      end
    end else if (tick) begin
      ph_d = ph_q + 2'h1;
      unique case (kind_q)
        seea_pkg::SEEA_OP_START: begin
          sda_low_d = ph_q[1];
          scl_low_d = (ph_q == 2'h0) || (ph_q == 2'h3);
        end
        seea_pkg::SEEA_OP_STOP: begin
          sda_low_d = !ph_q[1];
          scl_low_d = (ph_q == 2'h0);
        end
        default: begin
          scl_low_d = (ph_q == 2'h0) || (ph_q == 2'h3);
          if (ph_q == 2'h0) sda_low_d = drv;
          if (ph_q == 2'h2) begin
            if (bit_q != 4'h8 && kind_q == seea_pkg::SEEA_OP_RD) sh_d = {sh_q[6:0], sda_f_q};
            if (bit_q == 4'h8 && kind_q == seea_pkg::SEEA_OP_WR) nack_d = sda_f_q;
          end
          if (ph_q == 2'h3 && bit_q != 4'h8 && kind_q == seea_pkg::SEEA_OP_WR)
            sh_d = {sh_q[6:0], 1'b0};
        end
      endcase
      if (ph_q == 2'h3) begin
        if (kind_q == seea_pkg::SEEA_OP_START || kind_q == seea_pkg::SEEA_OP_STOP ||
            bit_q == 4'h8) begin
          eb_d = 1'b0; done_d = 1'b1;
        end else begin
          bit_d = bit_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0; eb_q <= 1'b0; done_q <= 1'b0; nack_q <= 1'b0; ackdrv_q <= 1'b0;
      ph_q <= 2'h0; bit_q <= 4'h0; sh_q <= 8'h00; kind_q <= seea_pkg::SEEA_OP_START;
      scl_low_q <= 1'b0; sda_low_q <= 1'b0;
      sda_s1_q <= 1'b1; sda_s2_q <= 1'b1; sda_s3_q <= 1'b1; sda_f_q <= 1'b1;
    end else begin
      div_q <= div_d; eb_q <= eb_d; done_q <= done_d; nack_q <= nack_d;
      ackdrv_q <= ackdrv_d; ph_q <= ph_d; bit_q <= bit_d; sh_q <= sh_d; kind_q <= kind_d;
      scl_low_q <= scl_low_d; sda_low_q <= sda_low_d;
      sda_s1_q <= sda_i; sda_s2_q <= sda_s1_q; sda_s3_q <= sda_s2_q; sda_f_q <= sda_f_d;
    end
  end

  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_low_q;
  assign sda_oe = sda_low_q;

  // ---------------------------------------------------------------------
  // Sequencer, boot loader and register file.
  // ---------------------------------------------------------------------
  seea_state_e st_q, st_d;
  seea_boot_e  bs_q, bs_d;
  logic issued_q, issued_d, boot_q, boot_d, xwr_q, xwr_d, err_q, err_d, pack_q, pack_d;
  logic [14:0] xaddr_q, xaddr_d, addr_q, addr_d;
  logic [15:0] xdata_q, xdata_d, rdw_q, rdw_d, data_q, data_d, prot_q, prot_d;
  logic [31:0] tmr_q, tmr_d, prdata_q, prdata_d;
  logic [3:0]  flags_q, flags_d, isr_q, isr_d, mask_q, mask_d, ev;
  logic [2:0]  strap_q, strap_d;
  logic [1:0]  csize_q, csize_d, esz;
  logic pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q, pin_f_d;
  logic ld_v_q, ld_v_d, defs_q, defs_d, bdone_q, bdone_d, pslverr_q, pslverr_d;
  logic [7:0] ld_a_q, ld_a_d;
  logic [15:0] ld_d_q, ld_d_d, bytea;
  logic apb_wr, apb_setup, cmd_wr, busy, size_bad, range_bad, prot_bad, in_win;

  assign apb_wr    = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign cmd_wr    = apb_wr && paddr == seea_pkg::CMD_OFS &&
                     (pwdata[seea_pkg::CMD_READ_BIT] || pwdata[seea_pkg::CMD_WRITE_BIT]);
  assign busy      = (st_q != S_IDLE);
  assign esz       = (csize_q == seea_pkg::SIZE_AUTO) ? detected_size_field : csize_q;
  assign size_bad  = (esz == seea_pkg::SIZE_UNKNOWN);
  assign range_bad = {1'b0, addr_q} >= seea_pkg::SIZE_ENTRIES[esz];
  assign prot_bad  = !seea_prot_ok(prot_q, addr_q, !pwdata[seea_pkg::CMD_READ_BIT]);
  assign bytea     = {xaddr_q, 1'b0};
  assign in_win    = paddr >= seea_pkg::WIN_BASE && paddr <= seea_pkg::WIN_LAST;

  always_comb begin
    op_kind = seea_pkg::SEEA_OP_WR;
    op_byte = 8'h00;
    op_ack  = 1'b0;
    unique case (st_q)
      S_START, S_RSTART, S_PSTART: op_kind = seea_pkg::SEEA_OP_START;
      S_STOP, S_PSTOP:             op_kind = seea_pkg::SEEA_OP_STOP;
      S_DEVW, S_PDEV:              op_byte = {DEV_ADDR, 1'b0};
      S_DEVR:                      op_byte = {DEV_ADDR, 1'b1};
      S_AHI:                       op_byte = bytea[15:8];
      S_ALO:                       op_byte = bytea[7:0];
      S_WRHI:                      op_byte = xdata_q[15:8];
      S_WRLO:                      op_byte = xdata_q[7:0];
      S_RDHI: begin op_kind = seea_pkg::SEEA_OP_RD; op_ack = 1'b1; end
      S_RDLO:                      op_kind = seea_pkg::SEEA_OP_RD;
      default: ;
    endcase
    op_go = !(st_q inside {S_STRAP, S_IDLE, S_FINISH}) && !eb_q && !issued_q;
  end

  always_comb begin
    st_d = st_q; bs_d = bs_q; issued_d = issued_q; boot_d = boot_q; xwr_d = xwr_q;
    err_d = err_q; pack_d = pack_q; xaddr_d = xaddr_q; xdata_d = xdata_q; rdw_d = rdw_q;
    addr_d = addr_q; data_d = data_q; prot_d = prot_q; flags_d = flags_q; mask_d = mask_q;
    csize_d = csize_q; strap_d = strap_q; ld_v_d = 1'b0; ld_a_d = ld_a_q; ld_d_d = ld_d_q;
    defs_d = defs_q; bdone_d = bdone_q; ev = 4'h0;
    tmr_d = (st_q inside {S_PSTART, S_PDEV, S_PSTOP}) ? tmr_q + 32'h0000_0001 : 32'h0000_0000;
    pin_f_d = (pin_s2_q == pin_s3_q) ? pin_s3_q : pin_f_q;
    if (op_go) issued_d = 1'b1;
    if (done_q) issued_d = 1'b0;
    unique case (st_q)
      S_STRAP: begin
        strap_d = strap_q + 3'h1;
        if (strap_q == 3'(seea_pkg::STRAP_SETTLE)) begin
          if (!pin_f_q) begin
            boot_d = 1'b1; bs_d = B_SIG; xwr_d = 1'b0; err_d = 1'b0;
            xaddr_d = seea_pkg::SIG_WORD_ADDR; st_d = S_START;
          end else begin
            defs_d = 1'b1; bdone_d = 1'b1; st_d = S_IDLE;
          end
        end
      end
      S_IDLE: if (cmd_wr) begin
        flags_d = 4'h0;
        xwr_d = !pwdata[seea_pkg::CMD_READ_BIT];
        xaddr_d = addr_q; xdata_d = data_q;
        err_d = size_bad || range_bad || prot_bad;
        st_d = (size_bad || range_bad || prot_bad) ? S_FINISH : S_START;
      end
      S_FINISH: begin
        st_d = S_IDLE;
        if (boot_q) begin
          if (err_q || (bs_q == B_SIG && rdw_q != seea_pkg::SIG_VALUE)) begin
            defs_d = 1'b1; bdone_d = 1'b1; boot_d = 1'b0;
          end else if (bs_q == B_SIG) begin
            bs_d = B_PROT; xaddr_d = seea_pkg::PROT_WORD_ADDR; st_d = S_START;
          end else if (bs_q == B_PROT) begin
            prot_d = rdw_q; bs_d = B_LOAD; xaddr_d = 15'h0000; st_d = S_START;
          end else begin
            ld_v_d = 1'b1; ld_a_d = xaddr_q[7:0]; ld_d_d = rdw_q;
            if (xaddr_q == seea_pkg::BOOT_LAST) begin
              bdone_d = 1'b1; boot_d = 1'b0;
            end else begin
              xaddr_d = xaddr_q + 15'h0001; st_d = S_START;
            end
          end
        end else if (xwr_q) begin
          ev[err_q ? seea_pkg::STS_WR_ERR : seea_pkg::STS_WR_DONE] = 1'b1;
        end else begin
          ev[err_q ? seea_pkg::STS_RD_ERR : seea_pkg::STS_RD_DONE] = 1'b1;
          if (!err_q) data_d = rdw_q;
        end
      end
      default: if (done_q) begin
        unique case (st_q)
          S_START:  st_d = S_DEVW;
          S_DEVW:   st_d = S_AHI;
          S_AHI:    st_d = S_ALO;
          S_ALO:    st_d = xwr_q ? S_WRHI : S_RSTART;
          S_RSTART: st_d = S_DEVR;
          S_DEVR:   st_d = S_RDHI;
          S_RDHI: begin rdw_d[15:8] = sh_q; st_d = S_RDLO; end
          S_RDLO: begin rdw_d[7:0] = sh_q; st_d = S_STOP; end
          S_WRHI:   st_d = S_WRLO;
          S_WRLO:   st_d = S_STOP;
          S_STOP:   st_d = (xwr_q && !err_q) ? S_PSTART : S_FINISH;
          S_PSTART: st_d = S_PDEV;
          S_PDEV: begin pack_d = !nack_q; st_d = S_PSTOP; end
          S_PSTOP: begin
            if (pack_q) st_d = S_FINISH;
            else if (tmr_q >= POLL_LIMIT) begin err_d = 1'b1; st_d = S_FINISH; end
            else st_d = S_PSTART;
          end
          default: st_d = S_IDLE;
        endcase
        // A missing acknowledge on any sent byte except the poll address byte is a protocol failure.
        if (nack_q && (st_q inside {S_DEVW, S_AHI, S_ALO, S_DEVR, S_WRHI, S_WRLO})) begin
          err_d = 1'b1; st_d = S_STOP;
        end
      end
    endcase
    flags_d = flags_d | ev;
    // A set in the same cycle as a one-write clear wins.
    isr_d = (isr_q & ~((apb_wr && paddr == seea_pkg::IRQ_STS_OFS) ? pwdata[3:0] : 4'h0)) | ev;
    if (apb_wr) begin
      unique case (paddr)
        seea_pkg::ADDR_OFS:     addr_d = pwdata[14:0];
        seea_pkg::DATA_OFS:     data_d = pwdata[15:0];
        seea_pkg::CFG_OFS:      csize_d = pwdata[1:0];
        seea_pkg::IRQ_MASK_OFS: mask_d = pwdata[3:0];
        default: ;
      endcase
    end
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (apb_setup) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        seea_pkg::ADDR_OFS:     prdata_d[14:0] = addr_q;
        seea_pkg::DATA_OFS:     prdata_d[15:0] = data_q;
        seea_pkg::CMD_OFS:      ;
        seea_pkg::CFG_OFS:      prdata_d[1:0] = csize_q;
        seea_pkg::STS_OFS:      prdata_d[6:0] = {defs_q, bdone_q, busy, flags_q};
        seea_pkg::IRQ_STS_OFS:  prdata_d[3:0] = isr_q;
        seea_pkg::IRQ_MASK_OFS: prdata_d[3:0] = mask_q;
        default:                pslverr_d = 1'b1;
      endcase
      if (!in_win) pslverr_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_STRAP; bs_q <= B_SIG; issued_q <= 1'b0; boot_q <= 1'b0; xwr_q <= 1'b0;
      err_q <= 1'b0; pack_q <= 1'b0; xaddr_q <= 15'h0000; xdata_q <= 16'h0000;
      rdw_q <= 16'h0000; addr_q <= 15'h0000; data_q <= 16'h0000; prot_q <= 16'h0000;
      tmr_q <= 32'h0000_0000; prdata_q <= 32'h0000_0000; flags_q <= 4'h0; isr_q <= 4'h0;
      mask_q <= 4'h0; strap_q <= 3'h0; csize_q <= seea_pkg::SIZE_AUTO;
      pin_s1_q <= 1'b1; pin_s2_q <= 1'b1; pin_s3_q <= 1'b1; pin_f_q <= 1'b1;
      ld_v_q <= 1'b0; ld_a_q <= 8'h00; ld_d_q <= 16'h0000; defs_q <= 1'b0;
      bdone_q <= 1'b0; pslverr_q <= 1'b0;
    end else begin
      st_q <= st_d; bs_q <= bs_d; issued_q <= issued_d; boot_q <= boot_d; xwr_q <= xwr_d;
      err_q <= err_d; pack_q <= pack_d; xaddr_q <= xaddr_d; xdata_q <= xdata_d;
      rdw_q <= rdw_d; addr_q <= addr_d; data_q <= data_d; prot_q <= prot_d;
      tmr_q <= tmr_d; prdata_q <= prdata_d; flags_q <= flags_d; isr_q <= isr_d;
      mask_q <= mask_d; strap_q <= strap_d; csize_q <= csize_d;
      pin_s1_q <= boot_load_enable_pin_n; pin_s2_q <= pin_s1_q; pin_s3_q <= pin_s2_q;
      pin_f_q <= pin_f_d; ld_v_q <= ld_v_d; ld_a_q <= ld_a_d; ld_d_q <= ld_d_d;
      defs_q <= defs_d; bdone_q <= bdone_d; pslverr_q <= pslverr_d;
    end
  end

  assign prdata           = prdata_q;
  assign pready           = 1'b1;
  assign pslverr          = pslverr_q && psel && penable;
  assign cfg_load_valid   = ld_v_q;
  assign cfg_load_addr    = ld_a_q;
  assign cfg_load_data    = ld_d_q;
  assign cfg_use_defaults = defs_q;
  assign boot_done        = bdone_q;
  assign irq              = |(isr_q & mask_q);

  // ---------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sig_mismatch_a: assert property (st_q == S_FINISH && boot_q && bs_q == B_SIG &&
      rdw_q != seea_pkg::SIG_VALUE |=> defs_q && bdone_q && !ld_v_q && st_q == S_IDLE)
    else $error("signature mismatch did not fall back to defaults");
  sig_stop_a: assert property (defs_q && bdone_q |-> !boot_q && !ld_v_q)
    else $error("boot continued after fallback");
  cmd_clear_a: assert property (st_q == S_IDLE && cmd_wr |=> flags_q == 4'h0 && busy)
    else $error("command did not clear flags or start");
  busy_ignore_a: assert property (busy && !(st_q inside {S_FINISH, S_STRAP}) && cmd_wr
      |=> $stable(xaddr_q))
    else $error("command taken while busy");
  read_data_a: assert property (st_q == S_FINISH && !boot_q && !xwr_q && !err_q
      |=> flags_q[seea_pkg::STS_RD_DONE] && data_q == $past(rdw_q))
    else $error("read completion without data");
  auto_size_a: assert property (st_q == S_IDLE && cmd_wr && csize_q == seea_pkg::SIZE_AUTO &&
      detected_size_field == seea_pkg::SIZE_UNKNOWN |=> ##1 flags_q[1] || flags_q[3])
    else $error("unknown auto size not rejected");
  prot_deny_a: assert property (st_q == S_IDLE && cmd_wr && prot_bad |=> ##1
      (flags_q & 4'h5) == 4'h0 && (flags_q & 4'hA) != 4'h0)
    else $error("protected access not rejected");
  write_wait_a: assert property ($rose(flags_q[seea_pkg::STS_WR_DONE])
      |-> $past(pack_q, 2) || $past(err_q, 2))
    else $error("write done without chip acknowledge");
  boot_end_a: assert property (ld_v_q && ld_a_q == seea_pkg::BOOT_LAST[7:0] |-> bdone_q)
    else $error("boot did not end after last image entry");
  idle_take_a: assert property (st_q == S_FINISH && !boot_q |=> st_q == S_IDLE && !busy)
    else $error("block not ready after completion");

  read_ok_c:  cover property (flags_q[seea_pkg::STS_RD_DONE]);
  write_ok_c: cover property (flags_q[seea_pkg::STS_WR_DONE]);
  load_c:     cover property (ld_v_q ##1 !ld_v_q);
  irq_c:      cover property (irq);
endmodule : seea_top
`default_nettype wire

// file: tb/seea_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module seea_eeprom_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic ack_en,
  output logic      sda_oe
);
  // -----------------------------------------------------------------
  // Byte framing and acknowledge of the memory chip.
  // -----------------------------------------------------------------
  int bit_n;
  initial begin
    bit_n  = 0;
    sda_oe = 1'b0;
  end
  // A start condition restarts the byte count.
  always @(negedge sda) if (scl) bit_n = 0;
  always @(posedge scl) bit_n = bit_n + 1;
  // The chip holds no data here; with ack_en low it refuses every byte.
  always @(negedge scl) sda_oe <= ack_en && (bit_n % 9 == 8);
endmodule : seea_eeprom_model
`default_nettype wire

// file: tb/test_serial_eeprom_access.sv
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module test_serial_eeprom_access;
  // -----------------------------------------------------------------
  // Design, memory chip and open-drain wires.
  // -----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        pin_n, scl_oe, sda_oe, m_oe, boot_done, use_def, irq, ack_en;
  logic [1:0]  det;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  int          fail_count, total_checks;
  int          cyc = 0;
  wire         scl = ~scl_oe;
  wire         sda = ~(sda_oe | m_oe);
  seea_top #(.WRITE_POLL_CYCLES(2000)) seea_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_load_enable_pin_n(pin_n), .detected_size_field(det), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .cfg_load_valid(), .cfg_load_addr(),
    .cfg_load_data(), .cfg_use_defaults(use_def), .boot_done(boot_done), .irq(irq));
  seea_eeprom_model seea_eeprom_model_inst (.scl(scl), .sda(sda), .ack_en(ack_en),
    .sda_oe(m_oe));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // Reference outcome: size check, range check, then the chip's answer.
  function automatic logic [3:0] exp_flags(input int wr, input int a, input int cfg);
    int sz;
    sz = (cfg == 0) ? int'(det) : cfg;
    if (sz != 0 && a < (128 << sz) && ack_en) return wr ? 4'h4 : 4'h1;
    return wr ? 4'h8 : 4'h2;
  endfunction : exp_flags
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic poll(input int wr, input int a, input int cfg);
    int n = 0;
    do begin
      apb(1'b0, seea_pkg::STS_OFS, '0);
      n++;
    end while ((rd[4] !== 1'b0 || rd[3:0] === 4'h0) && n < 30000);
    `chk(rd[3:0], exp_flags(wr, a, cfg))
  endtask : poll
  task automatic op(input int wr, input logic [14:0] a, input int cfg);
    seed = xs(seed);
    apb(1'b1, seea_pkg::CFG_OFS, 32'(cfg));
    apb(1'b1, seea_pkg::ADDR_OFS, {17'h0_0000, a});
    apb(1'b1, seea_pkg::DATA_OFS, {16'h0000, seed[15:0]});
    apb(1'b1, seea_pkg::CMD_OFS, wr ? 32'h0000_0002 : 32'h0000_0001);
    poll(wr, int'(a), cfg);
  endtask : op
  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // A hang costs one mismatch and ends the run.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, det, ack_en} = '0;
    pin_n = 1'b1;
    seed = 32'h0000_d962;
    fail_count = 0;
    total_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    `chk({boot_done, use_def}, 2'b11)
    apb(1'b0, seea_pkg::STS_OFS, '0);
    `chk(rd[6:5], 2'b11)
    apb(1'b0, 16'h601C, '0);
    `chk({err, rd}, {1'b1, 32'h0000_0000})
    for (int c = 0; c < 4; c++) begin
      seed = xs(seed);
      op(c % 2, 15'h0100 | seed[14:0], c / 2);
    end
    det <= 2'h2;
    apb(1'b1, seea_pkg::CFG_OFS, '0);
    apb(1'b1, seea_pkg::ADDR_OFS, 32'h0000_01FF);
    apb(1'b1, seea_pkg::CMD_OFS, 32'h0000_0001);
    apb(1'b1, seea_pkg::CMD_OFS, 32'h0000_0002);
    apb(1'b0, seea_pkg::STS_OFS, '0);
    `chk(rd[4:0], 5'h10)
    poll(0, 16'h01FF, 0);
    op(1, 15'h0010, 3);
    apb(1'b0, seea_pkg::IRQ_STS_OFS, '0);
    `chk({irq, rd[3:0]}, 5'h0A)
    apb(1'b1, seea_pkg::IRQ_MASK_OFS, 32'h0000_0008);
    `chk(irq, 1'b1)
    apb(1'b1, seea_pkg::IRQ_STS_OFS, 32'h0000_0008);
    apb(1'b0, seea_pkg::IRQ_STS_OFS, '0);
    `chk({irq, rd[3:0]}, 5'h02)
    // The chip model holds no array, so a released data line reads as all ones.
    ack_en <= 1'b1;
    op(0, 15'h0020, 3);
    apb(1'b0, seea_pkg::DATA_OFS, '0);
    `chk(rd[15:0], 16'hFFFF)
    stop_test();
  end
endmodule : test_serial_eeprom_access
`default_nettype wire
